// [verilog/fdsd_device.sv]
// Receive back-end: demodulators, post filter, slicer, clock recovery,
// sync word detection and strength readback.
// Assumes limited I/Q samples one per aclk and a 32x data-rate strobe.
//
// Functional notes
// [R01] Strength code sits in readback bits 7..1
// [R02] Readback also carries both gain codes
// [R03] Host: power = -98 dBm + (code+corr)/2
// [R04] Host: correction table from the gain codes
// [R05] Select 01 uses the correlator path
// [R06] Select 00 uses the linear path
// [R07] Two tone correlators, bit by magnitude compare
// [R08] Second-order low-pass, 10-bit cutoff coefficient
// [R09] Host programs coefficient from cutoff and clock
// [R10] Correlator slicer threshold fixed at zero
// [R11] 32x oversampled clock-recovery loop resyncs bits
// [R12] Correlator bandwidth set by 10-bit field
// [R13] Linear: discriminator, averaging, envelope, threshold
// [R14] Linear slicer feeds the same recovery loop
// [R15] Linear reuses same filter and coefficient
// [R16] In receive, sync match asserts lock output
// [R17] Lock drops after nine recovered bit clocks
// [R18] Sync detection only in modes 010, 011
// [R19] Sync length 12, 16, 20 or 24 bits
// [R20] Transmitter sends sync word MSB first
// [R21] Accept match with up to tolerance errors
// [R22] Length codes ascend: 12, 16, 20, 24
// [R23] Compare low word bits with newest bits
`timescale 1ns/10ps
module fdsd_device
  import fdsd_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              iq_i,
  input  wire logic              iq_q,
  input  wire logic              os_tick,
  input  wire logic [STR_W-1:0]  strength_code,
  input  wire logic [GAIN_W-1:0] front_amp_gain_code,
  input  wire logic [GAIN_W-1:0] chan_filter_gain_code,
  fdsd_link_if.dev               lnk
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // One first-order section; two in cascade make the second-order filter
  function automatic logic signed [ACC_W-1:0] lpf_step(
    input logic signed [ACC_W-1:0] y,
    input logic signed [ACC_W-1:0] x,
    input logic [COEF_W-1:0]       k
  );
    logic signed [ACC_W+11:0] d;
    logic signed [ACC_W+11:0] p;
    d = {{12{x[ACC_W-1]}}, x} - {{12{y[ACC_W-1]}}, y};
    p = d * $signed({{(ACC_W+2){1'b0}}, k});
    return y + p[ACC_W+COEF_SHIFT-1:COEF_SHIFT];
  endfunction

  // Number of mismatched bits in the compared window
  function automatic logic [4:0] popcnt(input logic [SYNC_W-1:0] v);
    logic [4:0] c;
    c = '0;
    for (int i = 0; i < SYNC_W; i++) begin
      c = c + {4'h0, v[i]};
    end
    return c;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                    i_p;
    logic                    q_p;
    logic [COEF_W-1:0]       win_cnt;
    logic [COEF_W-1:0]       up_cnt;
    logic [COEF_W-1:0]       dn_cnt;
    logic signed [ACC_W-1:0] corr_x;
    logic signed [ACC_W-1:0] y1;
    logic signed [ACC_W-1:0] y2;
    logic signed [ACC_W-1:0] env_hi;
    logic signed [ACC_W-1:0] env_lo;
    logic                    slice;
    logic                    sl_prev;
    logic [PH_W-1:0]         phase;
    logic                    bit_val;
    logic                    bit_clk;
    logic [SYNC_W-1:0]       shreg;
    logic [3:0]              hold;
    logic                    lock;
    logic [RB_W-1:0]         rb;
  } fdsd_dev_st_t;

  fdsd_dev_st_t            st_r;
  fdsd_dev_st_t            st_nxt;
  logic                    pos;
  logic                    neg;
  logic                    corr_sel;
  logic                    win_end;
  logic                    sync_on;
  logic                    bit_ev;
  logic [PH_W-1:0]         step;
  logic signed [ACC_W-1:0] x_in;
  logic signed [ACC_W:0]   env_sum;
  logic signed [ACC_W-1:0] thr;
  logic [31:0]             mask32;
  logic [SYNC_W-1:0]       sh_new;
  logic [4:0]              mism;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt  = st_r;
    // Rotation sense of the limited I/Q phasor: +1, -1 or none
    pos     = ~(st_r.i_p ^ iq_q) & (st_r.q_p ^ iq_i);
    neg     = (st_r.i_p ^ iq_q) & ~(st_r.q_p ^ iq_i);
    corr_sel = (lnk.demod_select_field == DSEL_CORR);     // [R05] [R06]
    win_end = ({1'b0, st_r.win_cnt} + 11'h001)
              >= {1'b0, lnk.correlator_bw_field};         // [R12]
    sync_on = lnk.rx_en &&
              (lnk.demod_mode_field == MODE_SYNC_A ||
               lnk.demod_mode_field == MODE_SYNC_B);      // [R18]
    bit_ev  = 1'b0;
    step    = PH_ONE;
    mask32  = (32'h00000001 << SYNC_LEN[lnk.sync_length_field])
              - 32'h00000001;                             // [R19] [R22]
    sh_new  = {st_r.shreg[SYNC_W-2:0], st_r.slice};
    mism    = popcnt((sh_new ^ lnk.sync_word)
                     & mask32[SYNC_W-1:0]);               // [R23]
    st_nxt.i_p = iq_i;
    st_nxt.q_p = iq_q;

    // Tone correlators: count each rotation sense over a window
    if (win_end) begin
      st_nxt.corr_x  = (st_r.up_cnt > st_r.dn_cnt)
                       ? DEC_LVL : -DEC_LVL;              // [R07]
      st_nxt.up_cnt  = '0;
      st_nxt.dn_cnt  = '0;
      st_nxt.win_cnt = '0;
    end else begin
      st_nxt.up_cnt  = st_r.up_cnt + {9'h000, pos};
      st_nxt.dn_cnt  = st_r.dn_cnt + {9'h000, neg};
      st_nxt.win_cnt = st_r.win_cnt + 10'h001;
    end

    // Path select: correlator decision or linear discriminator
    if (corr_sel) begin
      x_in = st_r.corr_x; // [R05]
    end else if (pos) begin
      x_in = DEC_LVL; // [R06] [R13]
    end else if (neg) begin
      x_in = -DEC_LVL;
    end else begin
      x_in = '0;
    end

    // Shared post filter for both paths
    st_nxt.y1 = lpf_step(st_r.y1, x_in, lnk.post_filter_coeff);  // [R08]
    st_nxt.y2 = lpf_step(st_r.y2, st_r.y1,
                         lnk.post_filter_coeff);          // [R15]

    // Envelope tracker; peaks decay slowly so long runs do not collapse it
    if (st_r.y2 > st_r.env_hi) begin
      st_nxt.env_hi = st_r.y2; // [R13]
    end else begin
      st_nxt.env_hi = st_r.env_hi
                      - ((st_r.env_hi - st_r.y2) >>> ENV_SHIFT);
    end
    if (st_r.y2 < st_r.env_lo) begin
      st_nxt.env_lo = st_r.y2;
    end else begin
      st_nxt.env_lo = st_r.env_lo
                      + ((st_r.y2 - st_r.env_lo) >>> ENV_SHIFT);
    end
    env_sum = {st_r.env_hi[ACC_W-1], st_r.env_hi}
              + {st_r.env_lo[ACC_W-1], st_r.env_lo};
    thr     = env_sum[ACC_W:1];

    // Slicer: zero threshold for correlator, envelope midpoint for linear
    if (corr_sel) begin
      st_nxt.slice = ~st_r.y2[ACC_W-1];                   // [R10]
    end else begin
      st_nxt.slice = (st_r.y2 > thr); // [R13]
    end

    // Recovery loop: edges pull the phase toward bit boundaries
    if (os_tick) begin
      st_nxt.sl_prev = st_r.slice; // [R14]
      if (st_r.slice != st_r.sl_prev && st_r.phase != PH_ZERO) begin
        step = (st_r.phase < PH_MID) ? PH_ZERO : PH_TWO;  // [R11]
      end
      st_nxt.phase   = st_r.phase + step;
      bit_ev         = (st_r.phase < PH_MID) &&
                       (st_r.phase + step >= PH_MID);
      st_nxt.bit_clk = st_nxt.phase[PH_W-1];
    end

    // Sync search runs once per recovered bit
    if (!sync_on) begin
      st_nxt.lock = 1'b0;
      st_nxt.hold = '0;
    end
    if (bit_ev) begin
      st_nxt.bit_val = st_r.slice; // [R11]
      st_nxt.shreg   = sh_new;
      if (sync_on && mism <= {3'h0, lnk.sync_tolerance_field}) begin
        st_nxt.lock = 1'b1; // [R16] [R21]
        st_nxt.hold = LOCK_HOLD;
      end else if (st_r.lock) begin
        st_nxt.hold = st_r.hold - 4'h1;
        if (st_r.hold == HOLD_LAST) begin
          st_nxt.lock = 1'b0; // [R17]
        end
      end
    end

    // Readback word, low and unused bits read zero
    st_nxt.rb = '0;
    st_nxt.rb[STR_LSB +: STR_W]    = strength_code;       // [R01]
    st_nxt.rb[FGAIN_LSB +: GAIN_W] = chan_filter_gain_code; // [R02]
    st_nxt.rb[AGAIN_LSB +: GAIN_W] = front_amp_gain_code;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign lnk.rx_data  = st_r.bit_val;
  assign lnk.rx_dclk  = st_r.bit_clk;
  assign lnk.int_lock = st_r.lock;
  assign lnk.readback = st_r.rb;

endmodule

// [verilog/fdsd_pkg.sv]
// Shared constants for the FSK demodulator / sync detector and its host.
// Assumes one clock domain; both ends import this package whole.
package fdsd_pkg;

  // ----------------------------------------------------------------
  // Readback word layout
  // ----------------------------------------------------------------
  localparam int RB_W      = 16;
  localparam int STR_W     = 7;
  localparam int STR_LSB   = 1;
  localparam int FGAIN_LSB = 8;
  localparam int AGAIN_LSB = 10;
  localparam int GAIN_W    = 2;

  // ----------------------------------------------------------------
  // Demodulator selection, modes and filter arithmetic
  // ----------------------------------------------------------------
  localparam logic [1:0] DSEL_LINEAR = 2'h0;
  localparam logic [1:0] DSEL_CORR   = 2'h1;
  localparam logic [2:0] MODE_SYNC_A = 3'h2;
  localparam logic [2:0] MODE_SYNC_B = 3'h3;
  localparam int COEF_W     = 10;
  localparam int ACC_W      = 18;
  localparam int COEF_SHIFT = 10;
  localparam int ENV_SHIFT  = 6;
  localparam logic signed [ACC_W-1:0] DEC_LVL = 18'h01000;

  // ----------------------------------------------------------------
  // Clock recovery (32 phases per bit) and sync detection
  // ----------------------------------------------------------------
  localparam int PH_W = 5;
  localparam logic [PH_W-1:0] PH_ZERO = 5'h00;
  localparam logic [PH_W-1:0] PH_ONE  = 5'h01;
  localparam logic [PH_W-1:0] PH_TWO  = 5'h02;
  localparam logic [PH_W-1:0] PH_MID  = 5'h10;
  localparam int SYNC_W = 24;
  localparam logic [4:0] SYNC_LEN [4] = '{5'h0C, 5'h10, 5'h14, 5'h18};
  localparam logic [3:0] LOCK_HOLD = 4'h9;
  localparam logic [3:0] HOLD_LAST = 4'h1;

  // ----------------------------------------------------------------
  // Gain-mode correction and power base (half-dB units, -196 = -98 dBm)
  // ----------------------------------------------------------------
  localparam logic [7:0] GC_HH = 8'h00;
  localparam logic [7:0] GC_MH = 8'h11;
  localparam logic [7:0] GC_MM = 8'h35;
  localparam logic [7:0] GC_ML = 8'h41;
  localparam logic [7:0] GC_LL = 8'h5A;
  localparam logic [7:0] GC_EL = 8'h71;
  localparam logic [9:0] PWR_BASE = 10'h33C;
  localparam int PWR_W = 10;

  // ----------------------------------------------------------------
  // Host register map (AXI4-Lite, byte addresses) and fields
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] A_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] A_COEF = 5'h04;
  localparam logic [ADDR_W-1:0] A_SYNC = 5'h08;
  localparam logic [ADDR_W-1:0] A_STAT = 5'h0C;
  localparam logic [ADDR_W-1:0] A_RXD  = 5'h10;
  localparam int RXEN_BIT = 0;
  localparam int DSEL_LSB = 1;
  localparam int MODE_LSB = 3;
  localparam int SLEN_LSB = 6;
  localparam int TOL_LSB  = 8;
  localparam int PCOEF_LSB = 0;
  localparam int CBW_LSB   = 16;
  localparam int LOCK_BIT  = 16;
  localparam int PWR_LSB   = 22;
  localparam int NSYNC_LSB = 24;
  localparam logic [31:0] CTRL_RST = 32'h00000002;
  localparam logic [31:0] COEF_RST = 32'h00090057;
  localparam logic [31:0] SYNC_RST = 32'h00000000;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [verilog/fdsd_link_if.sv]
// Link between the demodulator end and the host end.
// Assumes both ends share aclk; the bench instantiates and joins them.
`timescale 1ns/10ps
interface fdsd_link_if;
  import fdsd_pkg::*;

  // Configuration driven by the host, results driven by the device
  logic                rx_en;
  logic [1:0]          demod_select_field;
  logic [2:0]          demod_mode_field;
  logic [COEF_W-1:0]   post_filter_coeff;
  logic [COEF_W-1:0]   correlator_bw_field;
  logic [1:0]          sync_length_field;
  logic [1:0]          sync_tolerance_field;
  logic [SYNC_W-1:0]   sync_word;
  logic                rx_data;
  logic                rx_dclk;
  logic                int_lock;
  logic [RB_W-1:0]     readback;

  modport dev (
    input  rx_en, demod_select_field, demod_mode_field, post_filter_coeff,
           correlator_bw_field, sync_length_field, sync_tolerance_field,
           sync_word,
    output rx_data, rx_dclk, int_lock, readback
  );
  modport host (
    output rx_en, demod_select_field, demod_mode_field, post_filter_coeff,
           correlator_bw_field, sync_length_field, sync_tolerance_field,
           sync_word,
    input  rx_data, rx_dclk, int_lock, readback
  );
endinterface

// [verilog/fdsd_host.sv]
// Host end: AXI4-Lite register file that configures the demodulator,
// collects recovered bits and sync events, and converts strength to power.
// Assumes a single AXI4-Lite master on aclk.
`timescale 1ns/10ps
module fdsd_host
  import fdsd_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output wire logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output wire logic              s_axi_wready,
  output wire logic [1:0]        s_axi_bresp,
  output wire logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output wire logic              s_axi_arready,
  output wire logic [31:0]       s_axi_rdata,
  output wire logic [1:0]        s_axi_rresp,
  output wire logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  fdsd_link_if.host              lnk
);

  // Byte-lane merge for partial writes
  function automatic logic [31:0] wmerge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0]  strb
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              awr;
    logic              wr;
    logic              arr;
    logic              bv;
    logic [1:0]        br;
    logic              rv;
    logic [1:0]        rr;
    logic [31:0]       rd;
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] aw_a;
    logic [31:0]       wd;
    logic [3:0]        ws;
    logic [31:0]       ctrl;
    logic [31:0]       coef;
    logic [31:0]       sync;
    logic [SYNC_W-1:0] hist;
    logic [7:0]        nsync;
    logic              dclk_p;
    logic              lock_p;
    logic [PWR_W-1:0]  pwr;
  } fdsd_host_st_t;

  fdsd_host_st_t     st_r;
  fdsd_host_st_t     st_nxt;
  logic              have_aw;
  logic              have_w;
  logic [ADDR_W-1:0] wa;
  logic [7:0]        gc;
  logic [31:0]       stat;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt  = st_r;
    have_aw = st_r.aw_got | (s_axi_awvalid & st_r.awr);
    have_w  = st_r.w_got | (s_axi_wvalid & st_r.wr);
    wa      = st_r.aw_got ? st_r.aw_a : s_axi_awaddr;

    // Capture address and data in either order
    if (s_axi_awvalid && st_r.awr) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_a   = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wr) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wd    = s_axi_wdata;
      st_nxt.ws    = s_axi_wstrb;
    end
    if (st_r.bv && s_axi_bready) begin
      st_nxt.bv = 1'b0;
    end
    if (have_aw && have_w && !st_r.bv) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bv     = 1'b1;
      st_nxt.br     = RESP_OKAY;
      unique case (wa)
        A_CTRL: st_nxt.ctrl = wmerge(st_r.ctrl, st_nxt.wd, st_nxt.ws);
        A_COEF: st_nxt.coef = wmerge(st_r.coef, st_nxt.wd, st_nxt.ws);
        A_SYNC: st_nxt.sync = wmerge(st_r.sync, st_nxt.wd, st_nxt.ws);
        A_STAT, A_RXD: st_nxt.br = RESP_OKAY;
        default: st_nxt.br = RESP_SLVERR;
      endcase
    end
    // Ready only while the slot is free, so one write at a time
    st_nxt.awr = ~st_nxt.aw_got & ~st_nxt.bv;
    st_nxt.wr  = ~st_nxt.w_got & ~st_nxt.bv;

    // Gain-mode correction from the reported gain codes
    unique case ({lnk.readback[AGAIN_LSB +: GAIN_W],
                  lnk.readback[FGAIN_LSB +: GAIN_W]})
      4'hE: gc = GC_HH;                                   // [R04]
      4'hA: gc = GC_MH;
      4'h9: gc = GC_MM;
      4'h8: gc = GC_ML;
      4'h4: gc = GC_LL;
      4'h0: gc = GC_EL;
      default: gc = GC_HH;
    endcase
    st_nxt.pwr = PWR_BASE + {3'h0, lnk.readback[STR_LSB +: STR_W]}
                 + {2'h0, gc};                            // [R03]

    // Recovered bits on the rising data clock, sync events on lock rise
    st_nxt.dclk_p = lnk.rx_dclk;
    st_nxt.lock_p = lnk.int_lock;
    if (lnk.rx_dclk && !st_r.dclk_p) begin
      st_nxt.hist = {st_r.hist[SYNC_W-2:0], lnk.rx_data};
    end
    if (lnk.int_lock && !st_r.lock_p) begin
      st_nxt.nsync = st_r.nsync + 8'h01;
    end

    // Read channel
    stat = '0;
    stat[RB_W-1:0]          = lnk.readback;
    stat[LOCK_BIT]          = lnk.int_lock;
    stat[PWR_LSB +: PWR_W]  = st_r.pwr;
    if (st_r.rv && s_axi_rready) begin
      st_nxt.rv = 1'b0;
    end
    if (s_axi_arvalid && st_r.arr) begin
      st_nxt.rv = 1'b1;
      st_nxt.rr = RESP_OKAY;
      unique case (s_axi_araddr)
        A_CTRL: st_nxt.rd = st_r.ctrl;
        A_COEF: st_nxt.rd = st_r.coef;
        A_SYNC: st_nxt.rd = st_r.sync;
        A_STAT: st_nxt.rd = stat;
        A_RXD:  st_nxt.rd = {st_r.nsync, st_r.hist};
        default: begin
          st_nxt.rd = '0;
          st_nxt.rr = RESP_SLVERR;
        end
      endcase
    end
    st_nxt.arr = ~st_nxt.rv;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r      <= '0;
      st_r.awr  <= 1'b1;
      st_r.wr   <= 1'b1;
      st_r.arr  <= 1'b1;
      st_r.ctrl <= CTRL_RST;
      st_r.coef <= COEF_RST;
      st_r.sync <= SYNC_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Bus outputs and link configuration, all from flops
  assign s_axi_awready = st_r.awr;
  assign s_axi_wready  = st_r.wr;
  assign s_axi_bvalid  = st_r.bv;
  assign s_axi_bresp   = st_r.br;
  assign s_axi_arready = st_r.arr;
  assign s_axi_rvalid  = st_r.rv;
  assign s_axi_rresp   = st_r.rr;
  assign s_axi_rdata   = st_r.rd;
  assign lnk.rx_en                = st_r.ctrl[RXEN_BIT];
  assign lnk.demod_select_field   = st_r.ctrl[DSEL_LSB +: 2];
  assign lnk.demod_mode_field     = st_r.ctrl[MODE_LSB +: 3];
  assign lnk.sync_length_field    = st_r.ctrl[SLEN_LSB +: 2];
  assign lnk.sync_tolerance_field = st_r.ctrl[TOL_LSB +: 2];
  assign lnk.post_filter_coeff    = st_r.coef[PCOEF_LSB +: COEF_W]; // [R09]
  assign lnk.correlator_bw_field  = st_r.coef[CBW_LSB +: COEF_W];
  assign lnk.sync_word            = st_r.sync[SYNC_W-1:0];

endmodule

// [verification/fdsd_props.sv]
// Link checker for the demodulator and host ends.
// Assumes one clock; inputs are the link signals.
`timescale 1ns/10ps
module fdsd_props
  import fdsd_pkg::*;
(
  input logic            aclk,
  input logic            aresetn,
  input logic            rx_en,
  input logic [2:0]      demod_mode_field,
  input logic            rx_data,
  input logic            rx_dclk,
  input logic            int_lock,
  input logic [RB_W-1:0] readback
);
  // -------
  // Helpers
  // -------
  logic       srch;
  logic [3:0] nbit_r;
  assign srch = rx_en && (demod_mode_field inside {MODE_SYNC_A, MODE_SYNC_B});
  // Bit clocks since lock rose; saturates so a long hold cannot wrap
  always_ff @(posedge aclk) begin
    if (!aresetn || !int_lock) nbit_r <= 4'h0;
    else if ($rose(rx_dclk) && !$rose(int_lock) && nbit_r != 4'hF)
      nbit_r <= nbit_r + 4'h1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_lock_at_bit;
    $rose(int_lock) |-> $rose(rx_dclk) && $past(srch);
  endproperty
  property p_lock_nine;
    $fell(int_lock) && srch |-> $rose(rx_dclk) && nbit_r >= 4'h8;
  endproperty
  property p_lock_hold;
    $rose(int_lock) |=> (int_lock || !srch)[*8];
  endproperty
  property p_lock_off;
    !srch |=> !int_lock;
  endproperty
  property p_data_edge;
    $changed(rx_data) |-> $rose(rx_dclk);
  endproperty
  property p_dclk_half;
    $rose(rx_dclk) |=> rx_dclk[*7];
  endproperty
  property p_rb_fmt;
    readback[0] == 1'b0 && readback[RB_W-1:12] == 4'h0;
  endproperty
  property p_rst_zero;
    $rose(aresetn) |-> !int_lock && !rx_dclk && readback == 16'h0000;
  endproperty
  a_lock_at_bit: assert property (p_lock_at_bit)
    else $error("lock rose off a bit event");
  a_lock_nine: assert property (p_lock_nine)
    else $error("lock fell early");
  a_lock_hold: assert property (p_lock_hold)
    else $error("lock pulse too short");
  a_lock_off: assert property (p_lock_off)
    else $error("lock high with search off");
  a_data_edge: assert property (p_data_edge)
    else $error("data moved off clock rise");
  a_dclk_half: assert property (p_dclk_half)
    else $error("clock high too briefly");
  a_rb_fmt: assert property (p_rb_fmt)
    else $error("readback spare bits set");
  a_rst_zero: assert property (p_rst_zero)
    else $error("outputs set after reset");
  c_lock: cover property ($rose(int_lock));
  c_unlock: cover property ($fell(int_lock));
  c_one: cover property ($rose(rx_dclk) && rx_data);
endmodule

// [verification/fsk_demod_sync_detect_test.sv]
// Bench joining both ends; drives AXI, I/Q samples and gain inputs.
// Assumes os_tick every cycle, so one bit spans 32 clocks.
`timescale 1ns/10ps
module fsk_demod_sync_detect_test;
  import fdsd_pkg::*;
  logic              aclk, aresetn, iq_i, iq_q, awvalid, wvalid, bready;
  logic              awready, wready, bvalid, arvalid, arready, rvalid;
  logic              rready;
  logic [STR_W-1:0]  strength_code;
  logic [1:0]        front_amp_gain_code, chan_filter_gain_code, ph;
  logic [1:0]        bresp, rresp, r;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata, d;
  int                mismatches, compares, cyc, locks, hi_cnt, lock_len;
  localparam logic [23:0] SW = 24'h3C96E5;
  fdsd_link_if lnk();
  fdsd_device u_fdsd_device(.aclk(aclk), .aresetn(aresetn), .iq_i(iq_i),
    .iq_q(iq_q), .os_tick(1'b1), .strength_code(strength_code),
    .front_amp_gain_code(front_amp_gain_code),
    .chan_filter_gain_code(chan_filter_gain_code), .lnk(lnk));
  fdsd_host u_fdsd_host(.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .lnk(lnk));
  fdsd_props u_fdsd_props(.aclk(aclk), .aresetn(aresetn), .rx_en(lnk.rx_en),
    .demod_mode_field(lnk.demod_mode_field), .rx_data(lnk.rx_data),
    .rx_dclk(lnk.rx_dclk), .int_lock(lnk.int_lock), .readback(lnk.readback));
  always #50 aclk = ~aclk;
  // Lock pulse monitor and hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    hi_cnt <= (lnk.int_lock === 1'b1) ? hi_cnt + 1 : 0;
    if (lnk.int_lock === 1'b1 && hi_cnt == 0) locks <= locks + 1;
    if (lnk.int_lock === 1'b0 && hi_cnt != 0) lock_len <= hi_cnt;
    if (cyc == 40000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    r = bresp;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  // Rotating I/Q, one quarter turn a sample; sense gives the bit
  task automatic send(input logic [23:0] w, input int n);
    for (int b = n - 1; b >= 0; b--) begin
      for (int k = 0; k < 32; k++) begin
        @(posedge aclk);
        ph = w[b] ? ph + 2'h1 : ph - 2'h1;
        iq_i <= ~^ph;
        iq_q <= ~ph[1];
      end
    end
  endtask
  task automatic t_regs;
    rd(A_CTRL);
    chk("ctrl reset", CTRL_RST, d);
    rd(A_COEF);
    chk("coef reset", COEF_RST, d);
    rd(5'h14);
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(r));
    wr(5'h14, 32'hFFFFFFFF);
    chk("unmapped wr", 32'(RESP_SLVERR), 32'(r));
    wr(A_SYNC, {8'hFF, SW});
    rd(A_SYNC);
    chk("sync word", {8'hFF, SW}, d);
    $display("test regs done");
  endtask
  task automatic t_rssi;
    logic [3:0] gf [6] = '{4'hE, 4'hA, 4'h9, 4'h8, 4'h4, 4'h0};
    logic [7:0] gc [6] = '{8'h00, 8'h11, 8'h35, 8'h41, 8'h5A, 8'h71};
    for (int i = 0; i < 6; i++) begin
      strength_code <= 7'h7F - 7'(i * 21);
      {front_amp_gain_code, chan_filter_gain_code} <= gf[i];
      repeat (3) @(posedge aclk);
      rd(A_STAT);
      chk("readback", {20'h0, gf[i], strength_code, 1'b0}, 32'(d[15:0]));
      chk("power", 32'(10'(strength_code + gc[i]) + 10'h33C), 32'(d[31:22]));
    end
    $display("test rssi done");
  endtask
  task automatic sync_case(input logic [1:0] ds, input logic [2:0] md,
                           input logic [1:0] sl, tl, input logic [23:0] fl,
                           input int ex);
    int n0;
    wr(A_CTRL, {22'h0, tl, sl, md, ds, 1'b1});
    n0 = locks;
    send(24'hAAAAAA, 24);
    send(SW ^ fl, 12 + 4 * sl);
    send(24'hAAAA, 16);
    chk("lock count", 32'(ex), 32'(locks - n0));
    if (ex == 1) chk("lock length", 1, 32'(lock_len inside {[286:290]}));
    rd(A_RXD);
    chk("lock tally", 32'(8'(locks)), 32'(d[31:24]));
    chk("recent bits", 1, 32'(d[7:0] inside {8'hAA, 8'h55}));
  endtask
  task automatic t_sync;
    sync_case(DSEL_CORR, MODE_SYNC_A, 2'h0, 2'h0, 24'h0, 1);
    sync_case(DSEL_LINEAR, MODE_SYNC_B, 2'h3, 2'h0, 24'h0, 1);
    sync_case(DSEL_CORR, MODE_SYNC_A, 2'h1, 2'h3, 24'h111, 1);
    sync_case(DSEL_CORR, MODE_SYNC_B, 2'h2, 2'h1, 24'h3, 0);
    sync_case(DSEL_CORR, 3'h0, 2'h0, 2'h0, 24'h0, 0);
    $display("test sync done");
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    {aclk, aresetn, iq_i, iq_q, awvalid, wvalid, bready, arvalid} = 8'h00;
    {rready, ph, strength_code, awaddr, araddr, wdata} = 52'h0;
    {front_amp_gain_code, chan_filter_gain_code} = 4'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_rssi();
    t_sync();
    tally_and_finish();
  end
endmodule
